// ==== design/aal_cfg.svh ====
/*
 * constants for the add / logical-and execution unit: register offsets,
 * flag positions, reset values and cycle costs.
 * assumes it is included once per file by its bare name.
 */
// Functional notes
// - register add is full 36-bit, 2 cycles, one word
// - memory-to-register add: 6 cycles stack/long, 4 cycles short absolute
// - short absolute operand gives a 6-bit data address from the instruction
// - register-to-memory add writes back; 8 cycles stack/long, 6 short, two words
// - unsigned 0..31 immediate add: 4 cycles, one word
// - signed 16-bit extension-word immediate add: 6 cycles, two words
// - add with single or dual parallel move is one word, one instruction
// - add with parallel move costs 2 cycles plus move extra cycles
// - result register may not equal the parallel read target; writes allowed
// - dual parallel read rejected while execute-from-data-memory bit is set
// - register and is 16-bit; accumulator only bits 31..16 change
// - logical and ignores saturation, never limited
// - and: negative from bit 31 or register msb, overflow cleared
// - and: zero when bits 31..16 or whole register result are zero
// - register and takes 2 cycles and one word
// - immediate and is a bit clear with inverted 16-bit mask
// - immediate and reads destination, then writes it back separately
// - immediate and sets carry when all mask-selected bits are one
// - immediate and sets limit flag if 36-bit source move limited
// - immediate and on status register clears only mask-selected bits
// - 16-bit add source gets 16 low zeros and sign extension to 36
// - add carry flag set on carry or borrow out of accumulator result
`ifndef AAL_CFG_SVH
`define AAL_CFG_SVH
// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define AAL_OFF_X0      12'h000
`define AAL_OFF_Y0      12'h004
`define AAL_OFF_Y1      12'h008
`define AAL_OFF_A2      12'h00C
`define AAL_OFF_A1      12'h010
`define AAL_OFF_A0      12'h014
`define AAL_OFF_B2      12'h018
`define AAL_OFF_B1      12'h01C
`define AAL_OFF_B0      12'h020
`define AAL_OFF_STATUS  12'h024
`define AAL_OFF_OPMODE  12'h028
`define AAL_OFF_COST    12'h02C
`define AAL_MEM_BASE    12'h100
// ----------------------------------------------------------------------
// flag positions and reset values
// ----------------------------------------------------------------------
`define AAL_C_BIT       0
`define AAL_V_BIT       1
`define AAL_Z_BIT       2
`define AAL_N_BIT       3
`define AAL_L_BIT       6
`define AAL_EXEC_BIT    7
`define AAL_SR_RESET    16'h0000
`define AAL_OPM_RESET   16'h0000
// ----------------------------------------------------------------------
// cycle costs
// ----------------------------------------------------------------------
`define AAL_CYC_REG     5'd2
`define AAL_CYC_MEM     5'd6
`define AAL_CYC_SHORT   5'd4
`define AAL_CYC_TOMEM   5'd8
`define AAL_CYC_TOSHORT 5'd6
`define AAL_CYC_IMM5    5'd4
`define AAL_CYC_IMM16   5'd6
`define AAL_CYC_ANDI    5'd4
`endif

// ==== design/aal_pkg.sv ====
/*
 * types of the add / logical-and execution unit.
 * assumes nothing beyond a single clock domain.
 */
package aal_pkg;
  typedef enum logic [1:0] {OP_ADD, OP_AND, OP_ANDI} aal_op_t;
  typedef enum logic [3:0] {R_X0, R_Y0, R_Y1, R_A, R_B, R_A1, R_B1, R_Y, R_SR} aal_reg_t;
  typedef enum logic [1:0] {F_REG, F_MEM, F_IMM5, F_IMM16} aal_form_t;
  typedef enum logic [1:0] {AM_SP, AM_SHORT, AM_LONG} aal_amode_t;
  typedef enum logic [1:0] {PM_NONE, PM_READ, PM_WRITE, PM_DUAL} aal_pm_t;
  typedef enum logic {ST_IDLE, ST_RUN} aal_state_t;
endpackage : aal_pkg

// ==== design/aal_alu.sv ====
/*
 * add / logical-and execution unit with its data registers, status and
 * operating mode registers and a 64-word data memory window.
 * assumes a decoder on the same clock drives the instruction port and
 * computes effective addresses and move extra cycles.
 */
// Chosen here: strobed register access and the address map.
`include "aal_cfg.svh"

module aal_alu
  import aal_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        ins_valid,
  input  aal_op_t          ins_op,
  input  aal_form_t        ins_form,
  input  aal_reg_t         ins_src,
  input  aal_reg_t         ins_dst,
  input  wire logic        ins_dst_mem,
  input  aal_amode_t       ins_amode,
  input  wire logic [15:0] ins_addr,
  input  wire logic [5:0]  ins_short_addr,
  input  wire logic [15:0] ins_imm,
  input  aal_pm_t          ins_pm,
  input  aal_reg_t         ins_pm_reg,
  input  wire logic [15:0] ins_pm_addr,
  input  wire logic [1:0]  ins_pm_ptr,
  input  wire logic        ins_pm_inc_n,
  input  wire logic [15:0] ins_pm_addr2,
  input  wire logic [1:0]  ins_pm_ptr2,
  input  wire logic        ins_pm_dec2,
  input  wire logic [3:0]  ins_mv,
  output logic             busy,
  output logic             done,
  output logic             reject,
  output logic      [4:0]  cost_cycles,
  output logic      [1:0]  cost_words
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] x0_reg, y0_reg, y1_reg, sr_reg, opm_reg;
  logic [35:0] a_reg, b_reg;
  logic [15:0] mem [0:63];
  aal_state_t  state_reg;
  logic [4:0]  cnt_reg;
  logic [31:0] rdata_reg;
  logic        busy_reg, done_reg, reject_reg;
  logic [4:0]  cyc_reg;
  logic [1:0]  wrd_reg;
  aal_op_t     p_op_reg;
  logic        p_rwr_reg, p_mwr_reg, p_srwr_reg;
  aal_reg_t    p_dst_reg, p_pmr_reg;
  logic [35:0] p_val_reg;
  logic [5:0]  p_maddr_reg, p_pmaddr_reg;
  logic [15:0] p_sr_reg, p_pmval_reg, p_pmval2_reg;
  aal_pm_t     p_pm_reg;

  // ----------------------------------------------------------------------
  // operand helpers
  // ----------------------------------------------------------------------
  function automatic logic [35:0] get36(input aal_reg_t r);
    logic [15:0] w;
    w     = get16(r);
    get36 = 36'h0_0000_0000;
    case (r)
      R_A:     get36 = a_reg;
      R_B:     get36 = b_reg;
      R_Y:     get36 = {{4{y1_reg[15]}}, y1_reg, y0_reg};
      default: get36 = {{4{w[15]}}, w, 16'h0000};
    endcase
  endfunction : get36

  function automatic logic [15:0] get16(input aal_reg_t r);
    get16 = 16'h0000;
    case (r)
      R_X0:       get16 = x0_reg;
      R_Y0:       get16 = y0_reg;
      R_Y1:       get16 = y1_reg;
      R_A, R_A1:  get16 = a_reg[31:16];
      R_B, R_B1:  get16 = b_reg[31:16];
      R_SR:       get16 = sr_reg;
      default:    get16 = y1_reg;
    endcase
  endfunction : get16

  function automatic logic is_acc(input aal_reg_t r);
    is_acc = (r == R_A) || (r == R_B);
  endfunction : is_acc

  // parallel read target overlapping the arithmetic result
  function automatic logic clash(input aal_reg_t p, input aal_reg_t d);
    clash = (p == d) || (p == R_A1 && d == R_A) || (p == R_B1 && d == R_B);
  endfunction : clash

  // ----------------------------------------------------------------------
  // decode: cost, legality and addresses
  // ----------------------------------------------------------------------
  logic        accept;
  logic        illegal;
  logic [4:0]  cyc_next;
  logic [1:0]  wrd_next;
  logic [5:0]  ea;
  logic        is_short;

  assign accept   = ins_valid && (state_reg == ST_IDLE);
  assign is_short = (ins_amode == AM_SHORT);
  assign ea       = is_short ? ins_short_addr : ins_addr[5:0];

  // cost table per form
  always_comb
  begin
    cyc_next = `AAL_CYC_REG;
    wrd_next = 2'd1;
    if (ins_pm != PM_NONE)
    begin
      cyc_next = `AAL_CYC_REG + {1'b0, ins_mv};
      wrd_next = 2'd1;
    end
    else if (ins_op == OP_ANDI)
    begin
      cyc_next = (ins_dst_mem && !is_short) ? `AAL_CYC_MEM : `AAL_CYC_ANDI;
      wrd_next = (ins_dst_mem && ins_amode == AM_LONG) ? 2'd3 : 2'd2;
    end
    else if (ins_op == OP_AND)
    begin
      cyc_next = `AAL_CYC_REG;
      wrd_next = 2'd1;
    end
    else if (ins_dst_mem)
    begin
      cyc_next = is_short ? `AAL_CYC_TOSHORT : `AAL_CYC_TOMEM;
      wrd_next = 2'd2;
    end
    else
    begin
      case (ins_form)
        F_MEM:
        begin
          cyc_next = is_short ? `AAL_CYC_SHORT : `AAL_CYC_MEM;
          wrd_next = (ins_amode == AM_LONG) ? 2'd2 : 2'd1;
        end
        F_IMM5:  cyc_next = `AAL_CYC_IMM5;
        F_IMM16:
        begin
          cyc_next = `AAL_CYC_IMM16;
          wrd_next = 2'd2;
        end
        default: cyc_next = `AAL_CYC_REG;
      endcase
    end
  end

  // illegal parallel forms are refused without side effects
  always_comb
  begin
    illegal = 1'b0;
    if (ins_pm != PM_NONE && (ins_op != OP_ADD || ins_form != F_REG || ins_dst_mem))
      illegal = 1'b1;
    if ((ins_pm == PM_READ || ins_pm == PM_DUAL) && clash(ins_pm_reg, ins_dst))
      illegal = 1'b1;
    if (ins_pm == PM_DUAL && opm_reg[`AAL_EXEC_BIT])
      illegal = 1'b1;
    if (ins_pm == PM_DUAL && (ins_pm_ptr[1] || ins_pm_ptr2 != 2'd3 ||
        (ins_pm_reg != R_Y0 && ins_pm_reg != R_Y1)))
      illegal = 1'b1;
  end

  // ----------------------------------------------------------------------
  // datapath: result and flags computed when taken
  // ----------------------------------------------------------------------
  logic [35:0] s36, d36, r36;
  logic [36:0] sum37;
  logic [15:0] s16, d16, r16, mask;
  logic [16:0] sum17;
  logic [15:0] sr_new;
  logic [35:0] val_new;

  always_comb
  begin
    s16     = (ins_form == F_MEM) ? mem[ea] :
              (ins_form == F_IMM5) ? {11'h000, ins_imm[4:0]} :
              (ins_form == F_IMM16) ? ins_imm : get16(ins_src);
    s36     = (ins_form == F_REG) ? get36(ins_src) : {{4{s16[15]}}, s16, 16'h0000};
    d36     = get36(ins_dst);
    d16     = ins_dst_mem ? mem[ea] : get16(ins_dst);
    sum37   = {1'b0, d36} + {1'b0, s36};
    r36     = sum37[35:0];
    sum17   = {1'b0, d16} + {1'b0, (ins_dst_mem ? get16(ins_src) : s16)};
    r16     = sum17[15:0];
    mask    = ~ins_imm;
    sr_new  = sr_reg;
    val_new = d36;
    case (ins_op)
      OP_ADD:
      begin
        if (is_acc(ins_dst) && !ins_dst_mem)
        begin
          val_new = r36;
          sr_new[`AAL_C_BIT] = sum37[36];
          sr_new[`AAL_V_BIT] = (d36[35] == s36[35]) && (r36[35] != d36[35]);
          sr_new[`AAL_Z_BIT] = (r36 == 36'h0_0000_0000);
          sr_new[`AAL_N_BIT] = r36[35];
        end
        else
        begin
          val_new = {20'h0_0000, r16};
          sr_new[`AAL_C_BIT] = sum17[16];
          sr_new[`AAL_V_BIT] = (d16[15] == s16[15]) && (r16[15] != d16[15]);
          sr_new[`AAL_Z_BIT] = (r16 == 16'h0000);
          sr_new[`AAL_N_BIT] = r16[15];
        end
      end
      OP_AND:
      begin
        // mid word only, no saturation path
        r16     = d16 & s16;
        val_new = {d36[35:32], r16, d36[15:0]};
        sr_new[`AAL_N_BIT] = r16[15];
        sr_new[`AAL_Z_BIT] = (r16 == 16'h0000);
        sr_new[`AAL_V_BIT] = 1'b0;
      end
      default:
      begin
        r16 = d16 & ~mask;
        if (!ins_dst_mem && ins_dst == R_SR)
          sr_new = sr_reg & ~mask;
        else
        begin
          val_new = {d36[35:32], r16, d36[15:0]};
          sr_new[`AAL_C_BIT] = ((d16 & mask) == mask);
          sr_new[`AAL_L_BIT] = sr_reg[`AAL_L_BIT] |
            (is_acc(ins_dst) && !ins_dst_mem && (d36[35:31] != {5{d36[31]}}));
        end
        if (!is_acc(ins_dst) || ins_dst_mem)
          val_new = {20'h0_0000, r16};
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer: take, count, commit
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 5'd0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      reject_reg <= 1'b0;
    end
    else
    begin
      done_reg   <= 1'b0;
      reject_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
          if (accept && illegal)
            reject_reg <= 1'b1;
          else if (accept)
          begin
            state_reg <= ST_RUN;
            cnt_reg   <= cyc_next - 5'd1;
            busy_reg  <= 1'b1;
          end
        ST_RUN:
          if (cnt_reg == 5'd1)
          begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 5'd1;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // pending results, captured when the instruction is taken
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cyc_reg <= 5'd0;
      wrd_reg <= 2'd0;
      p_op_reg <= OP_ADD;
      p_rwr_reg <= 1'b0;
      p_mwr_reg <= 1'b0;
      p_srwr_reg <= 1'b0;
      p_pm_reg <= PM_NONE;
    end
    else if (accept && !illegal)
    begin
      cyc_reg      <= cyc_next;
      wrd_reg      <= wrd_next;
      p_op_reg     <= ins_op;
      p_mwr_reg    <= ins_dst_mem;
      p_rwr_reg    <= !ins_dst_mem && !(ins_op == OP_ANDI && ins_dst == R_SR);
      p_srwr_reg   <= 1'b1;
      p_dst_reg    <= ins_dst;
      p_val_reg    <= val_new;
      p_maddr_reg  <= ea;
      p_sr_reg     <= sr_new;
      p_pm_reg     <= ins_pm;
      p_pmr_reg    <= ins_pm_reg;
      p_pmaddr_reg <= ins_pm_addr[5:0];
      p_pmval_reg  <= (ins_pm == PM_WRITE) ? get16(ins_pm_reg) : mem[ins_pm_addr[5:0]];
      p_pmval2_reg <= mem[ins_pm_addr2[5:0]];
    end
  end

  logic commit;
  assign commit = (state_reg == ST_RUN) && (cnt_reg == 5'd1);

  // ----------------------------------------------------------------------
  // register file: bus writes, then commit results on top
  // ----------------------------------------------------------------------
  logic [15:0] x0_next, y0_next, y1_next, sr_next, opm_next;
  logic [35:0] a_next, b_next;

  always_comb
  begin
    x0_next = x0_reg; y0_next = y0_reg; y1_next = y1_reg;
    a_next = a_reg; b_next = b_reg; sr_next = sr_reg; opm_next = opm_reg;
    if (bus_wr)
      case (bus_addr)
        `AAL_OFF_X0:     x0_next = bus_wdata[15:0];
        `AAL_OFF_Y0:     y0_next = bus_wdata[15:0];
        `AAL_OFF_Y1:     y1_next = bus_wdata[15:0];
        `AAL_OFF_A2:     a_next[35:32] = bus_wdata[3:0];
        `AAL_OFF_A1:     a_next[31:16] = bus_wdata[15:0];
        `AAL_OFF_A0:     a_next[15:0] = bus_wdata[15:0];
        `AAL_OFF_B2:     b_next[35:32] = bus_wdata[3:0];
        `AAL_OFF_B1:     b_next[31:16] = bus_wdata[15:0];
        `AAL_OFF_B0:     b_next[15:0] = bus_wdata[15:0];
        `AAL_OFF_STATUS: sr_next = bus_wdata[15:0];
        `AAL_OFF_OPMODE: opm_next = bus_wdata[15:0];
        default:         ;
      endcase
    if (commit)
    begin
      if (p_srwr_reg)
        sr_next = p_sr_reg;
      if (p_rwr_reg)
        case (p_dst_reg)
          R_X0:       x0_next = p_val_reg[15:0];
          R_Y0:       y0_next = p_val_reg[15:0];
          R_Y1:       y1_next = p_val_reg[15:0];
          R_A:        a_next = p_val_reg;
          R_B:        b_next = p_val_reg;
          R_A1:       a_next[31:16] = p_val_reg[15:0];
          R_B1:       b_next[31:16] = p_val_reg[15:0];
          default:    ;
        endcase
      if (p_pm_reg == PM_READ || p_pm_reg == PM_DUAL)
        case (p_pmr_reg)
          R_X0:    x0_next = p_pmval_reg;
          R_Y0:    y0_next = p_pmval_reg;
          R_Y1:    y1_next = p_pmval_reg;
          R_A:     a_next = {{4{p_pmval_reg[15]}}, p_pmval_reg, 16'h0000};
          R_B:     b_next = {{4{p_pmval_reg[15]}}, p_pmval_reg, 16'h0000};
          R_A1:    a_next[31:16] = p_pmval_reg;
          R_B1:    b_next[31:16] = p_pmval_reg;
          default: ;
        endcase
      if (p_pm_reg == PM_DUAL)
        x0_next = p_pmval2_reg;
    end
  end

  // data registers follow their next values
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      x0_reg <= 16'h0000; y0_reg <= 16'h0000; y1_reg <= 16'h0000;
      a_reg <= 36'h0_0000_0000; b_reg <= 36'h0_0000_0000;
      sr_reg <= `AAL_SR_RESET; opm_reg <= `AAL_OPM_RESET;
    end
    else
    begin
      x0_reg <= x0_next; y0_reg <= y0_next; y1_reg <= y1_next;
      a_reg <= a_next; b_reg <= b_next; sr_reg <= sr_next; opm_reg <= opm_next;
    end
  end

  // data memory: bus word writes, write-back and parallel writes
  always_ff @(posedge clk)
  begin
    if (bus_wr && bus_addr[11:8] == 4'h1)
      mem[bus_addr[7:2]] <= bus_wdata[15:0];
    if (commit && p_mwr_reg)
      mem[p_maddr_reg] <= p_val_reg[15:0];
    if (commit && p_pm_reg == PM_WRITE)
      mem[p_pmaddr_reg] <= p_pmval_reg;
  end

  // ----------------------------------------------------------------------
  // bus read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_reg <= 32'h0000_0000;
    else if (!bus_rd)
      rdata_reg <= 32'h0000_0000;
    else if (bus_addr[11:8] == 4'h1)
      rdata_reg <= {16'h0000, mem[bus_addr[7:2]]};
    else
      case (bus_addr)
        `AAL_OFF_X0:     rdata_reg <= {16'h0000, x0_reg};
        `AAL_OFF_Y0:     rdata_reg <= {16'h0000, y0_reg};
        `AAL_OFF_Y1:     rdata_reg <= {16'h0000, y1_reg};
        `AAL_OFF_A2:     rdata_reg <= {28'h000_0000, a_reg[35:32]};
        `AAL_OFF_A1:     rdata_reg <= {16'h0000, a_reg[31:16]};
        `AAL_OFF_A0:     rdata_reg <= {16'h0000, a_reg[15:0]};
        `AAL_OFF_B2:     rdata_reg <= {28'h000_0000, b_reg[35:32]};
        `AAL_OFF_B1:     rdata_reg <= {16'h0000, b_reg[31:16]};
        `AAL_OFF_B0:     rdata_reg <= {16'h0000, b_reg[15:0]};
        `AAL_OFF_STATUS: rdata_reg <= {16'h0000, sr_reg};
        `AAL_OFF_OPMODE: rdata_reg <= {16'h0000, opm_reg};
        `AAL_OFF_COST:   rdata_reg <= {24'h00_0000, busy_reg, wrd_reg, cyc_reg};
        default:         rdata_reg <= 32'h0000_0000;
      endcase
  end

  assign bus_rdata   = rdata_reg;
  assign busy        = busy_reg;
  assign done        = done_reg;
  assign reject      = reject_reg;
  assign cost_cycles = cyc_reg;
  assign cost_words  = wrd_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic        take;
  logic [4:0]  age_reg;
  assign take = accept && !illegal;

  // cycles since the last instruction was taken, take edge counted as one
  always_ff @(posedge clk)
    if (reset)
      age_reg <= 5'd0;
    else
      age_reg <= take ? 5'd1 : age_reg + 5'd1;

  a_reg_add_two: assert property (take && ins_op == OP_ADD && ins_form == F_REG &&
    !ins_dst_mem && ins_pm == PM_NONE |-> !done ##1 !done ##1 done)
    else $error("register add not two cycles");
  a_mem_src_cost: assert property (take && ins_op == OP_ADD && ins_form == F_MEM &&
    !ins_dst_mem && ins_pm == PM_NONE |-> ##1 cost_cycles == (is_short ? 5'd4 : 5'd6))
    else $error("memory add cost wrong");
  a_mem_dst_eight: assert property (take && ins_op == OP_ADD && ins_dst_mem &&
    !is_short |-> ##8 done && cost_words == 2'd2)
    else $error("add to memory not eight cycles");
  a_imm16_six: assert property (take && ins_op == OP_ADD && ins_form == F_IMM16 &&
    !ins_dst_mem |-> ##1 busy [*5] ##1 done && cost_words == 2'd2)
    else $error("long immediate add timing wrong");
  a_par_one_word: assert property (take && ins_pm != PM_NONE |-> ##1 cost_words == 2'd1)
    else $error("parallel add not one word");
  a_par_timing: assert property (done |-> age_reg == cost_cycles)
    else $error("done not at cost");
  a_dual_refused: assert property (accept && ins_pm == PM_DUAL &&
    opm_reg[`AAL_EXEC_BIT] |=> reject && !busy)
    else $error("dual read taken with exec bit");
  a_clash_refused: assert property (accept && ins_pm == PM_READ &&
    ins_pm_reg == ins_dst |=> reject ##1 !done)
    else $error("parallel read clash taken");
  a_and_v_clear: assert property (done && p_op_reg == OP_AND |=> !sr_reg[`AAL_V_BIT])
    else $error("and left overflow set");
  a_and_low_kept: assert property (take && ins_op == OP_AND && ins_dst == R_A &&
    !bus_wr |-> ##2 $stable(a_reg[15:0]))
    else $error("and touched low word");

  c_reg_add:  cover property (take && ins_op == OP_ADD && ins_form == F_REG);
  c_dual:     cover property (take && ins_pm == PM_DUAL);
  c_andi_sr:  cover property (take && ins_op == OP_ANDI && ins_dst == R_SR);
  c_rejected: cover property (reject);

endmodule : aal_alu

// ==== tb/aal_alu_test.sv ====
/* bench for aal_alu: adds, logical ands, immediate and, dual-read refusal.
   assumes the design package and aal_cfg.svh are compiled before it. */
`include "aal_cfg.svh"
module aal_alu_test
  import aal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, bus_wr = 0, bus_rd = 0, ins_valid = 0, ins_dst_mem = 0;
  logic [11:0] bus_addr = 0;
  logic [31:0] bus_wdata = 0, bus_rdata, rv;
  aal_op_t op = OP_ADD;
  aal_form_t form = F_REG;
  aal_reg_t src = R_X0, dst = R_A;
  aal_amode_t am = AM_SHORT;
  aal_pm_t pm = PM_NONE;
  logic [15:0] imm = 0;
  logic [5:0] sa = 0;
  aal_reg_t pmr = R_Y0;
  logic [3:0] mv = 0;
  logic [15:0] addr = 0;
  logic [1:0] ptr = 0;
  logic busy, done, reject;
  logic [4:0] cost_cycles;
  logic [1:0] cost_words;
  int err_count = 0, check_count = 0;
  // ----------------------------------------
  // clock and design
  // ----------------------------------------
  always #4 clk = ~clk;
  aal_alu u_aal_alu (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ins_valid(ins_valid),
    .ins_op(op), .ins_form(form), .ins_src(src), .ins_dst(dst), .ins_dst_mem(ins_dst_mem),
    .ins_amode(am), .ins_addr(addr), .ins_short_addr(sa), .ins_imm(imm), .ins_pm(pm),
    .ins_pm_reg(pmr), .ins_pm_addr(16'h0002), .ins_pm_ptr(ptr), .ins_pm_inc_n(1'b0),
    .ins_pm_addr2(16'h0003), .ins_pm_ptr2(2'h3), .ins_pm_dec2(1'b0), .ins_mv(mv),
    .busy(busy), .done(done), .reject(reject), .cost_cycles(cost_cycles),
    .cost_words(cost_words));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1; bus_addr <= a; bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge clk);
    bus_rd <= 1; bus_addr <= a;
    @(posedge clk);
    bus_rd <= 0;
    #1 rv = bus_rdata;
  endtask : rd
  // offer one instruction, count edges to done or reject
  task run(input int cyc, input logic rej);
    int n;
    @(posedge clk);
    ins_valid <= 1;
    @(posedge clk);
    ins_valid <= 0;
    n = 1;
    #1;
    while (done !== 1 && reject !== 1 && n < 40)
    begin
      @(posedge clk);
      n++;
      #1;
    end
    chk("latency", n, cyc);
    chk("reject", reject, rej);
  endtask : run
  task final_report;
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_add;
    wr(`AAL_OFF_X0, 32'h0000_FFFF);
    wr(`AAL_OFF_A1, 32'h0000_0100);
    run(2, 0);
    rd(`AAL_OFF_COST); chk("cost", rv, 32'h0000_0022);
    rd(`AAL_OFF_A1); chk("a1", rv, 32'h0000_00FF);
    rd(`AAL_OFF_STATUS); chk("carry", rv[`AAL_C_BIT], 1);
  endtask : t_add
  task t_and;
    op <= OP_AND;
    wr(`AAL_OFF_X0, 32'h0000_F0F0);
    wr(`AAL_OFF_A2, 32'h0000_0006);
    wr(`AAL_OFF_A1, 32'h0000_8F0F);
    wr(`AAL_OFF_A0, 32'h0000_5678);
    run(2, 0);
    rd(`AAL_OFF_A1); chk("a1", rv, 32'h0000_8000);
    rd(`AAL_OFF_A2); chk("a2", rv, 32'h0000_0006);
    rd(`AAL_OFF_A0); chk("a0", rv, 32'h0000_5678);
    rd(`AAL_OFF_STATUS); chk("nzv", rv[3:1], 3'b100);
  endtask : t_and
  task t_andi;
    op <= OP_ANDI; form <= F_IMM16; ins_dst_mem <= 1; sa <= 6'h05; imm <= 16'h5555;
    wr(`AAL_MEM_BASE + 12'h014, 32'h0000_C3FF);
    run(4, 0);
    rd(`AAL_MEM_BASE + 12'h014); chk("mem", rv, 32'h0000_4155);
    rd(`AAL_OFF_STATUS); chk("carry", rv[`AAL_C_BIT], 0);
  endtask : t_andi
  task t_imm5;
    op <= OP_ADD; form <= F_IMM5; ins_dst_mem <= 0; imm <= 16'h001F;
    run(4, 0);
    chk("words", cost_words, 1);
  endtask : t_imm5
  task t_par;
    form <= F_REG; pm <= PM_READ; pmr <= R_Y1; mv <= 4'h3;
    run(5, 0);
    chk("words", cost_words, 1);
  endtask : t_par
  task t_dual;
    form <= F_REG; pm <= PM_DUAL; pmr <= R_Y0;
    wr(`AAL_OFF_OPMODE, 32'h0000_0080);
    run(1, 1);
  endtask : t_dual
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 0;
    rd(`AAL_OFF_STATUS); chk("status", rv, 32'h0000_0000);
    t_add;
    t_and;
    t_andi;
    t_imm5;
    t_par;
    t_dual;
    final_report;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    final_report;
  end
endmodule : aal_alu_test
